// ===== hw/spd_pkg.sv
// Constants, register map and state encoding of the stop mode power-down controller
package spd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SPD_ADDR_KEY = 8'h00;
  localparam logic [7:0] SPD_ADDR_CLKCTRL = 8'h01;
  localparam logic [7:0] SPD_ADDR_STAB = 8'h02;
  localparam logic [7:0] SPD_ADDR_STATUS = 8'h03;

  // ****************************************
  // Reset values and key codes
  // ****************************************
  localparam logic [7:0] SPD_KEY_VALUE = 8'hA5;
  localparam logic [7:0] SPD_KEY_RESET = 8'h00;
  localparam logic [7:0] SPD_HALT_OPCODE = 8'h7F;
  localparam logic [7:0] SPD_CLKCTRL_RESET = 8'h00;
  localparam logic [7:0] SPD_STAB_RESET = 8'h00;
  localparam logic [15:0] SPD_BOOT_VECTOR = 16'h0100;

  // ****************************************
  // Clock divider field
  // ****************************************
  localparam int SPD_CLKDIV_LSB = 3;
  localparam int SPD_CLKDIV_MSB = 4;
  localparam logic [1:0] SPD_CLKDIV_SLOW = 2'h0;

  // ****************************************
  // Wake cause codes
  // ****************************************
  localparam logic [1:0] SPD_CAUSE_NONE = 2'h0;
  localparam logic [1:0] SPD_CAUSE_RESET = 2'h1;
  localparam logic [1:0] SPD_CAUSE_IRQ = 2'h2;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [4:0] {
    SPD_RUN = 5'h01,
    SPD_STOP = 5'h02,
    SPD_RST_HOLD = 5'h04,
    SPD_STAB_RST = 5'h08,
    SPD_STAB_IRQ = 5'h10
  } spd_state_t;

endpackage : spd_pkg

// ===== hw/spd_stop_ctrl.sv
// Stop mode power-down controller: entry on keyed halt, exit on reset pin or interrupt
`timescale 1ns/1ps
module spd_stop_ctrl
  import spd_pkg::*;
#(
  parameter int WAKE_LINES = 16,
  parameter int STAB_UNIT_CYC = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic external_reset_pin_i,
  input wire logic [WAKE_LINES-1:0] external_wake_interrupt_lines_i,
  input wire logic internal_irq_i,
  output logic cpu_halt_o,
  output logic periph_halt_o,
  output logic osc_enable_o,
  output logic osc_pins_ground_o,
  output logic regfile_hold_o,
  output logic ctrl_reg_reset_o,
  output logic [1:0] clk_div_sel_o,
  output logic boot_fetch_o,
  output logic [15:0] fetch_addr_o,
  output logic wake_service_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  localparam int SYNC_W = WAKE_LINES + 1;
  localparam int STAB_W = 14;

  if (WAKE_LINES < 1 || WAKE_LINES > 16) begin : g_bad_lines
    $error("WAKE_LINES must be 1 to 16");
  end
  if (STAB_UNIT_CYC < 1 || STAB_UNIT_CYC > 32) begin : g_bad_unit
    $error("STAB_UNIT_CYC must be 1 to 32");
  end

  // ****************************************
  // Pin synchronisers, three stages with agreement filter
  // ****************************************
  logic [SYNC_W-1:0] sync_s1;
  logic [SYNC_W-1:0] sync_s2;
  logic [SYNC_W-1:0] sync_s3;
  logic [SYNC_W-1:0] sync_filt;
  logic [SYNC_W-1:0] sync_agree;

  // Reset pin idles high and wake lines idle low, so no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, {WAKE_LINES{1'b0}}};

  assign sync_agree = ~(sync_s2 ^ sync_s3);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_s1 <= SYNC_IDLE;
      sync_s2 <= SYNC_IDLE;
      sync_s3 <= SYNC_IDLE;
      sync_filt <= SYNC_IDLE;
    end else begin
      sync_s1 <= {external_reset_pin_i, external_wake_interrupt_lines_i};
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sync_filt <= (sync_s3 & sync_agree) | (sync_filt & ~sync_agree);
    end
  end

  logic pin_high;
  logic ext_wake;
  logic any_wake;

  assign pin_high = sync_filt[WAKE_LINES];
  assign ext_wake = |sync_filt[WAKE_LINES-1:0];
  assign any_wake = ext_wake | internal_irq_i;

  // ****************************************
  // State machine
  // ****************************************
  spd_state_t state;
  spd_state_t next_state;
  logic [7:0] stop_key_reg;
  logic [7:0] clock_divider_ctrl_reg;
  logic [7:0] stab_time_reg;
  logic [STAB_W-1:0] stab_cnt;
  logic [STAB_W-1:0] stab_load;
  logic halt_seen;
  logic key_ok;

  assign halt_seen = opcode_valid_i && (opcode_i == SPD_HALT_OPCODE);
  assign key_ok = (stop_key_reg == SPD_KEY_VALUE);
  assign stab_load = STAB_W'((16'(stab_time_reg) + 16'h0001) * 16'(STAB_UNIT_CYC) - 16'h0001);

  always_comb begin
    next_state = state;
    unique case (state)
      SPD_RUN: begin
        if (!pin_high) begin
          next_state = SPD_RST_HOLD;
        end else if (halt_seen && key_ok) begin
          next_state = SPD_STOP;
        end
      end
      SPD_STOP: begin
        if (!pin_high) begin
          next_state = SPD_RST_HOLD;
        end else if (any_wake) begin
          next_state = SPD_STAB_IRQ;
        end
      end
      SPD_RST_HOLD: begin
        if (pin_high) begin
          next_state = SPD_STAB_RST;
        end
      end
      SPD_STAB_RST: begin
        if (!pin_high) begin
          next_state = SPD_RST_HOLD;
        end else if (stab_cnt == '0) begin
          next_state = SPD_RUN;
        end
      end
      SPD_STAB_IRQ: begin
        if (!pin_high) begin
          next_state = SPD_RST_HOLD;
        end else if (stab_cnt == '0) begin
          next_state = SPD_RUN;
        end
      end
      default: begin
        next_state = SPD_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= SPD_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Stabilisation counter, loaded as the wait begins
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stab_cnt <= '0;
    end else if ((next_state == SPD_STAB_RST || next_state == SPD_STAB_IRQ) &&
                 next_state != state) begin
      stab_cnt <= stab_load;
    end else if (stab_cnt != '0) begin
      stab_cnt <= stab_cnt - STAB_W'(1);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic exit_stop;
  logic wr_key;
  logic wr_clk;
  logic wr_stab;
  logic [1:0] wake_cause;

  assign exit_stop = (state == SPD_STOP) && (next_state != SPD_STOP);
  assign wr_key = reg_wr_i && (reg_addr_i == SPD_ADDR_KEY);
  assign wr_clk = reg_wr_i && (reg_addr_i == SPD_ADDR_CLKCTRL);
  assign wr_stab = reg_wr_i && (reg_addr_i == SPD_ADDR_STAB);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_key_reg <= SPD_KEY_RESET;
    end else if (exit_stop || state == SPD_RST_HOLD) begin
      stop_key_reg <= SPD_KEY_RESET;
    end else if (wr_key) begin
      stop_key_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clock_divider_ctrl_reg <= SPD_CLKCTRL_RESET;
      stab_time_reg <= SPD_STAB_RESET;
    end else if (state == SPD_RST_HOLD) begin
      clock_divider_ctrl_reg <= SPD_CLKCTRL_RESET;
      stab_time_reg <= SPD_STAB_RESET;
    end else if (state == SPD_RUN) begin
      if (wr_clk) begin
        clock_divider_ctrl_reg <= reg_wdata_i;
      end
      if (wr_stab) begin
        stab_time_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_cause <= SPD_CAUSE_NONE;
    end else if (next_state == SPD_STAB_RST && state == SPD_RST_HOLD) begin
      wake_cause <= SPD_CAUSE_RESET;
    end else if (exit_stop && next_state == SPD_STAB_IRQ) begin
      wake_cause <= SPD_CAUSE_IRQ;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        SPD_ADDR_KEY: reg_rdata_o <= stop_key_reg;
        SPD_ADDR_CLKCTRL: reg_rdata_o <= clock_divider_ctrl_reg;
        SPD_ADDR_STAB: reg_rdata_o <= stab_time_reg;
        SPD_ADDR_STATUS: reg_rdata_o <= {1'b0, wake_cause, state};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cpu_halt_o = (state != SPD_RUN);
  assign periph_halt_o = (state != SPD_RUN);
  assign osc_enable_o = (state != SPD_STOP);
  assign osc_pins_ground_o = (state == SPD_STOP);
  assign regfile_hold_o = (state != SPD_RUN);
  assign ctrl_reg_reset_o = (state == SPD_RST_HOLD);
  assign clk_div_sel_o = clock_divider_ctrl_reg[SPD_CLKDIV_MSB:SPD_CLKDIV_LSB];

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_fetch_o <= 1'b0;
      wake_service_o <= 1'b0;
      fetch_addr_o <= 16'h0000;
    end else begin
      boot_fetch_o <= (state == SPD_STAB_RST) && (next_state == SPD_RUN);
      wake_service_o <= (state == SPD_STAB_IRQ) && (next_state == SPD_RUN);
      fetch_addr_o <= SPD_BOOT_VECTOR;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_keyed_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RUN && pin_high && halt_seen && key_ok) |=> (state == SPD_STOP))
    else $error("keyed halt did not enter stop");

  a_unkeyed_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RUN && halt_seen && !key_ok) |=> (state != SPD_STOP))
    else $error("halt without key entered stop");

  a_stop_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STOP) |-> (cpu_halt_o && periph_halt_o && !osc_enable_o))
    else $error("something still runs in stop");

  a_regfile_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STOP) |-> (regfile_hold_o && !ctrl_reg_reset_o))
    else $error("register file not held in stop");

  a_stop_exit_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STOP && pin_high && !any_wake) |=> (state == SPD_STOP))
    else $error("stop left without cause");

  a_reset_div: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RST_HOLD) |=> (clk_div_sel_o == SPD_CLKDIV_SLOW && !boot_fetch_o))
    else $error("reset did not clear divider");

  a_boot_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    boot_fetch_o |-> (fetch_addr_o == SPD_BOOT_VECTOR && $past(state) == SPD_STAB_RST))
    else $error("boot fetch wrong");

  a_irq_keep_div: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STOP && pin_high && any_wake) |=>
      ($stable(clk_div_sel_o) && state == SPD_STAB_IRQ) ##1 $stable(clk_div_sel_o))
    else $error("interrupt exit changed divider");

  a_key_cleared: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    exit_stop |=> (stop_key_reg == SPD_KEY_RESET))
    else $error("key survived exit");

  a_stab_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STAB_IRQ && stab_cnt != '0 && pin_high) |=> (state == SPD_STAB_IRQ))
    else $error("stabilisation wait cut short");

  a_service_after: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wake_service_o |-> ($past(state) == SPD_STAB_IRQ && state == SPD_RUN))
    else $error("wake service out of place");

  a_pins_ground: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(osc_pins_ground_o) |-> ($past(state) == SPD_RUN))
    else $error("pins grounded outside stop entry");

  a_run_stays: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RUN && pin_high && !halt_seen) |=> (state == SPD_RUN))
    else $error("run left without halt or reset");

  a_hold_until_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RST_HOLD && !pin_high) |=> (state == SPD_RST_HOLD))
    else $error("reset hold left while pin low");

  a_hold_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_RST_HOLD) |=> (stop_key_reg == SPD_KEY_RESET && stab_time_reg == SPD_STAB_RESET))
    else $error("reset hold kept control values");

  a_reset_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state == SPD_STAB_RST && stab_cnt != '0 && pin_high) |=> (state == SPD_STAB_RST))
    else $error("reset stabilisation wait cut short");

  a_ctrl_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (state != SPD_RUN && state != SPD_RST_HOLD) |=>
      ($stable(clock_divider_ctrl_reg) && $stable(stab_time_reg)))
    else $error("control register changed while halted");

  a_pulse_single: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (boot_fetch_o || wake_service_o) |=> !(boot_fetch_o || wake_service_o))
    else $error("resume pulse longer than one cycle");

endmodule : spd_stop_ctrl

// ===== bench/spd_cpu_model.sv
// Partner model of the CPU core, interrupt sources and external reset pin
`timescale 1ns/1ps
module spd_cpu_model
  import spd_pkg::*;
#(
  parameter logic [7:0] NOP_OPCODE = 8'hFF
) (
  input wire logic sys_clk_i,
  output logic opcode_valid_o,
  output logic [7:0] opcode_o,
  output logic reset_pin_o,
  output logic [15:0] wake_lines_o,
  output logic internal_irq_o
);
  initial begin
    opcode_valid_o = 1'b0;
    opcode_o = NOP_OPCODE;
    reset_pin_o = 1'b1;
    wake_lines_o = 16'h0000;
    internal_irq_o = 1'b0;
  end

  // Halt is one executed opcode; no-operations follow it
  task automatic exec_halt();
    @(posedge sys_clk_i);
    opcode_valid_o <= 1'b1;
    opcode_o <= SPD_HALT_OPCODE;
    @(posedge sys_clk_i);
    opcode_valid_o <= 1'b0;
    opcode_o <= NOP_OPCODE;
  endtask : exec_halt

  // Any other executed opcode, to show that only the halt enters stop
  task automatic exec_op(input logic [7:0] op);
    @(posedge sys_clk_i);
    opcode_valid_o <= 1'b1;
    opcode_o <= op;
    @(posedge sys_clk_i);
    opcode_valid_o <= 1'b0;
    opcode_o <= NOP_OPCODE;
  endtask : exec_op

  // Sources 0 to 15 are wake lines, 16 is the internal request
  task automatic raise_wake(input int src);
    @(posedge sys_clk_i);
    if (src < 16) begin
      wake_lines_o[src] <= 1'b1;
    end else begin
      internal_irq_o <= 1'b1;
    end
  endtask : raise_wake

  task automatic drop_wake();
    @(posedge sys_clk_i);
    wake_lines_o <= 16'h0000;
    internal_irq_o <= 1'b0;
  endtask : drop_wake

  task automatic set_reset(input logic level);
    @(posedge sys_clk_i);
    reset_pin_o <= level;
  endtask : set_reset
endmodule : spd_cpu_model

// ===== bench/tb_top.sv
// Self-checking testbench of the stop mode power-down controller
`timescale 1ns/1ps
module tb_top
  import spd_pkg::*;
;
  localparam int UNIT = 2;
  logic sys_clk_i, rst_b_i, reg_wr_i, reg_rd_i, opcode_valid_i, ext_rst, irq;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, opcode_i, v;
  logic [15:0] wake, fetch_addr_o;
  logic cpu_halt_o, periph_halt_o, osc_enable_o, osc_pins_ground_o, regfile_hold_o;
  logic ctrl_reg_reset_o, boot_fetch_o, wake_service_o;
  logic [1:0] clk_div_sel_o;
  int mismatches, comparisons, n, lo;

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  spd_stop_ctrl #(.WAKE_LINES(16), .STAB_UNIT_CYC(UNIT)) i_dut (
    .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .opcode_valid_i, .opcode_i, .external_reset_pin_i(ext_rst),
    .external_wake_interrupt_lines_i(wake), .internal_irq_i(irq), .cpu_halt_o, .periph_halt_o,
    .osc_enable_o, .osc_pins_ground_o, .regfile_hold_o, .ctrl_reg_reset_o, .clk_div_sel_o,
    .boot_fetch_o, .fetch_addr_o, .wake_service_o
  );

  spd_cpu_model i_cpu (
    .sys_clk_i, .opcode_valid_o(opcode_valid_i), .opcode_o(opcode_i), .reset_pin_o(ext_rst),
    .wake_lines_o(wake), .internal_irq_o(irq)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // Counts cycles until the boot or wake pulse, bounded
  task automatic wait_pulse(input logic boot, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk_i);
      #1 cnt++;
      if (cnt > 2000) begin
        mismatches++;
        conclude();
      end
    end while ((boot ? boot_fetch_o : wake_service_o) !== 1'b1);
  endtask : wait_pulse

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    check(fetch_addr_o, SPD_BOOT_VECTOR);
    rd(SPD_ADDR_KEY, v);
    check(16'(v), 16'(SPD_KEY_RESET));
    rd(SPD_ADDR_STATUS, v);
    check(16'(v), 16'h0001);
    wr(8'h10, 8'hFF);
    rd(8'h10, v);
    check(16'(v), 16'h0000);
    rd(SPD_ADDR_CLKCTRL, v);
    check(16'(v), 16'(SPD_CLKCTRL_RESET));
    i_cpu.exec_halt();
    repeat (2) @(posedge sys_clk_i);
    #1 check(16'(cpu_halt_o), 16'h0000);
    wr(SPD_ADDR_CLKCTRL, 8'h18);
    for (int i = 0; i < 17; i++) begin
      lo = (i % 4 + 1) * UNIT;
      wr(SPD_ADDR_STAB, 8'(i % 4));
      wr(SPD_ADDR_KEY, SPD_KEY_VALUE);
      i_cpu.exec_halt();
      repeat (2) @(posedge sys_clk_i);
      #1 check(16'({cpu_halt_o, periph_halt_o, osc_enable_o}), 16'h0006);
      check(16'({osc_pins_ground_o, regfile_hold_o}), 16'h0003);
      repeat (10) @(posedge sys_clk_i);
      #1 check(16'(cpu_halt_o), 16'h0001);
      // Divider writes are refused while halted
      wr(SPD_ADDR_CLKCTRL, 8'h00);
      i_cpu.raise_wake(i);
      wait_pulse(1'b0, n);
      // Wake lines pass the pin filter in four cycles, the internal request in none
      check(16'(n), 16'(lo + ((i < 16) ? 5 : 1)));
      check(16'({cpu_halt_o, osc_enable_o}), 16'h0001);
      check(16'(clk_div_sel_o), 16'h0003);
      i_cpu.drop_wake();
      rd(SPD_ADDR_KEY, v);
      check(16'(v), 16'h0000);
      rd(SPD_ADDR_CLKCTRL, v);
      check(16'(v), 16'h0018);
      rd(SPD_ADDR_STATUS, v);
      check(16'(v), 16'h0041);
      repeat (6) @(posedge sys_clk_i);
    end
    // The key was cleared on exit, so a bare halt must be ignored
    i_cpu.exec_halt();
    repeat (2) @(posedge sys_clk_i);
    #1 check(16'(cpu_halt_o), 16'h0000);
    // A keyed opcode other than the halt must not enter stop
    wr(SPD_ADDR_KEY, SPD_KEY_VALUE);
    i_cpu.exec_op(8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1 check(16'(cpu_halt_o), 16'h0000);
    wr(SPD_ADDR_STAB, 8'h02);
    wr(SPD_ADDR_KEY, SPD_KEY_VALUE);
    i_cpu.exec_halt();
    repeat (2) @(posedge sys_clk_i);
    i_cpu.set_reset(1'b0);
    repeat (6) @(posedge sys_clk_i);
    #1 check(16'({ctrl_reg_reset_o, regfile_hold_o}), 16'h0003);
    check(16'(clk_div_sel_o), 16'(SPD_CLKDIV_SLOW));
    i_cpu.set_reset(1'b1);
    wait_pulse(1'b1, n);
    // Pin filter, one entry edge, then the default wait of one unit
    check(16'(n), 16'(UNIT + 5));
    check(fetch_addr_o, SPD_BOOT_VECTOR);
    check(16'({ctrl_reg_reset_o, cpu_halt_o}), 16'h0000);
    rd(SPD_ADDR_CLKCTRL, v);
    check(16'(v), 16'h0000);
    rd(SPD_ADDR_STAB, v);
    check(16'(v), 16'(SPD_STAB_RESET));
    rd(SPD_ADDR_KEY, v);
    check(16'(v), 16'h0000);
    rd(SPD_ADDR_STATUS, v);
    check(16'(v), 16'h0021);
    conclude();
  end
endmodule : tb_top
